// ---- rx_gain_filter_calibration_control.sv ----
/*
  Receive front-end control: gain word mapping, input offset servo and filter cutoff
  calibration start. Assumes a register port with address, data and write strobe, and
  an analog side that returns an averaged offset and a filter calibration done flag.
*/
// How it works
// - A 6-bit gain word sets the receive amplifier from -12 dB to +48 dB in 1 dB steps.
// - A 3-bit alternative code sets -12 dB to +36 dB in 8 dB steps.
// - The coarse section is two cascaded stages spanning -12..+42 dB in 6 dB steps.
// - The fine section adds 0 to 6 dB in 1 dB steps.
// - A lookup table gives every stage its own setting from the gain value.
// - Offset cancellation runs after reset and whenever the host requests it.
// - During cancellation the input is shorted and every stage is forced high.
// - A servo steps a calibration DAC until the offset is within +/-32 LSB or the DAC reaches a rail.
// - Each write of the cutoff target starts a filter calibration of at most 100 us.
// - The filter is enabled after reset; clearing bit 0 at 0x07 bypasses it.
// - An 8-bit cutoff target is held at 0x08.
`timescale 1ns/1ps
module rx_gain_filter_calibration_control #(
  parameter int CAL_DAC_W = rx_ctrl_pkg::CAL_DAC_W,
  parameter int FILTER_CAL_CYC = rx_ctrl_pkg::FILTER_CAL_CYC
) (
  input  wire logic                 CLK_I,
  input  wire logic                 RST_N_I,
  input  wire logic [7:0]           REG_ADDR_I,
  input  wire logic [7:0]           REG_WDATA_I,
  input  wire logic                 REG_WR_I,
  output logic      [7:0]           REG_RDATA_O,
  input  wire logic [5:0]           GAIN_WORD_I,
  input  wire logic [2:0]           ALT_GAIN_I,
  input  wire logic                 ALT_GAIN_SEL_I,
  input  wire logic                 OFFSET_CAL_REQ_I,
  input  wire logic                 OFFSET_VALID_I,
  input  wire logic signed [11:0]   OFFSET_MEAS_I,
  input  wire logic                 FILTER_CAL_DONE_I,
  output logic      [1:0]           COARSE_STAGE1_O,
  output logic      [2:0]           COARSE_STAGE2_O,
  output logic      [2:0]           FINE_GAIN_O,
  output logic                      INPUT_SHORT_O,
  output logic [CAL_DAC_W-1:0]      CAL_DAC_O,
  output logic                      OFFSET_CAL_BUSY_O,
  output logic                      FILTER_ENABLE_O,
  output logic      [7:0]           CUTOFF_TARGET_O,
  output logic                      FILTER_CAL_START_O,
  output logic                      FILTER_CAL_BUSY_O
);
  // ==========================================================
  // gain selection
  logic [5:0] gain_step;
  logic [5:0] alt_step;
  logic [2:0] alt_clip;
  logic [1:0] lut_s1;
  logic [2:0] lut_s2;
  logic [2:0] lut_fine;
  // short codes above the top step saturate at +36 dB rather than wrap
  assign alt_clip = (ALT_GAIN_I > rx_ctrl_pkg::ALT_MAX_CODE) ? rx_ctrl_pkg::ALT_MAX_CODE
                                                              : ALT_GAIN_I;
  assign alt_step = 6'(alt_clip) * rx_ctrl_pkg::ALT_STEP_CODES;
  assign gain_step = ALT_GAIN_SEL_I ? alt_step
                   : (GAIN_WORD_I > rx_ctrl_pkg::GAIN_MAX_CODE) ? rx_ctrl_pkg::GAIN_MAX_CODE
                   : GAIN_WORD_I;

  gain_lut u_lut (
    .step_i   (gain_step),
    .stage1_o (lut_s1),
    .stage2_o (lut_s2),
    .fine_o   (lut_fine)
  );

  // ==========================================================
  // registers at 0x07 and 0x08
  logic [7:0] filter_power;
  logic [7:0] cutoff_target;
  logic       wr_power;
  logic       wr_target;
  logic [7:0] next_rdata;
  assign wr_power  = REG_WR_I && (REG_ADDR_I == rx_ctrl_pkg::ADDR_FILTER_POWER);
  assign wr_target = REG_WR_I && (REG_ADDR_I == rx_ctrl_pkg::ADDR_CUTOFF_TARGET);
  assign next_rdata = (REG_ADDR_I == rx_ctrl_pkg::ADDR_FILTER_POWER)  ? filter_power
                    : (REG_ADDR_I == rx_ctrl_pkg::ADDR_CUTOFF_TARGET) ? cutoff_target
                    : 8'h00;

  // register storage; other bits of 0x07 are kept for neighbouring blocks
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      filter_power  <= rx_ctrl_pkg::FILTER_POWER_RESET;
      cutoff_target <= rx_ctrl_pkg::CUTOFF_RESET;
    end else begin
      if (wr_power) filter_power <= REG_WDATA_I;
      if (wr_target) cutoff_target <= REG_WDATA_I;
    end
  end

  // ==========================================================
  // filter calibration timer
  logic [$clog2(FILTER_CAL_CYC+1)-1:0] fcal_cnt;
  logic                                fcal_busy;
  logic                                fcal_end;
  // analog done or the timeout ends the run, so it never exceeds the limit
  assign fcal_end = fcal_busy && (FILTER_CAL_DONE_I ||
                    (fcal_cnt == ($clog2(FILTER_CAL_CYC+1))'(FILTER_CAL_CYC)));

  // a write always wins and restarts the count, even mid-run
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      fcal_busy <= 1'b0;
      fcal_cnt  <= '0;
    end else if (wr_target) begin
      fcal_busy <= 1'b1;
      fcal_cnt  <= '0;
    end else if (fcal_end) begin
      fcal_busy <= 1'b0;
    end else if (fcal_busy) begin
      fcal_cnt  <= fcal_cnt + 1'b1;
    end
  end

  // ==========================================================
  // offset cancellation servo
  rx_ctrl_pkg::oc_state_t oc_state;
  rx_ctrl_pkg::oc_state_t next_oc_state;
  logic [4:0]             settle_cnt;
  logic [CAL_DAC_W-1:0]   cal_dac;
  logic                   in_window;
  logic                   too_high;
  logic                   dac_at_rail;
  assign in_window = (OFFSET_MEAS_I <= $signed({1'b0, rx_ctrl_pkg::OFFSET_LIMIT[10:0]})) &&
                     (OFFSET_MEAS_I >= -$signed({1'b0, rx_ctrl_pkg::OFFSET_LIMIT[10:0]}));
  assign too_high  = OFFSET_MEAS_I > 12'sh000;
  // a stuck rail would loop forever, so the servo gives up there
  assign dac_at_rail = too_high ? (cal_dac == '0) : (cal_dac == '1);

  // state decode for the servo
  always_comb begin
    next_oc_state = oc_state;
    unique case (oc_state)
      rx_ctrl_pkg::OC_IDLE:   if (OFFSET_CAL_REQ_I) next_oc_state = rx_ctrl_pkg::OC_SETTLE;
      rx_ctrl_pkg::OC_SETTLE: if (settle_cnt == 5'(rx_ctrl_pkg::SETTLE_CYC - 1))
                                next_oc_state = rx_ctrl_pkg::OC_MEAS;
      rx_ctrl_pkg::OC_MEAS:   if (OFFSET_VALID_I)
                                next_oc_state = (in_window || dac_at_rail)
                                              ? rx_ctrl_pkg::OC_IDLE
                                              : rx_ctrl_pkg::OC_SETTLE;
      default:                next_oc_state = rx_ctrl_pkg::OC_IDLE;
    endcase
  end

  // reset lands in SETTLE so the servo runs once after power-up
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      oc_state   <= rx_ctrl_pkg::OC_SETTLE;
      settle_cnt <= '0;
      cal_dac    <= {1'b1, {(CAL_DAC_W-1){1'b0}}};
    end else begin
      oc_state   <= next_oc_state;
      settle_cnt <= (oc_state == rx_ctrl_pkg::OC_SETTLE) ? settle_cnt + 5'h01 : 5'h00;
      if (oc_state == rx_ctrl_pkg::OC_MEAS && OFFSET_VALID_I && !in_window && !dac_at_rail)
        cal_dac <= too_high ? cal_dac - 1'b1 : cal_dac + 1'b1;
    end
  end

  // ==========================================================
  // output registers
  logic oc_active;
  assign oc_active = (next_oc_state != rx_ctrl_pkg::OC_IDLE);

  // stage settings: forced high gain while the servo runs
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      COARSE_STAGE1_O    <= 2'h0;
      COARSE_STAGE2_O    <= 3'h0;
      FINE_GAIN_O        <= 3'h0;
      INPUT_SHORT_O      <= 1'b0;
      CAL_DAC_O          <= '0;
      OFFSET_CAL_BUSY_O  <= 1'b0;
      FILTER_ENABLE_O    <= 1'b0;
      CUTOFF_TARGET_O    <= 8'h00;
      FILTER_CAL_START_O <= 1'b0;
      FILTER_CAL_BUSY_O  <= 1'b0;
      REG_RDATA_O        <= 8'h00;
    end else begin
      COARSE_STAGE1_O    <= oc_active ? 2'h3 : lut_s1;
      COARSE_STAGE2_O    <= oc_active ? rx_ctrl_pkg::STAGE_HIGH_GAIN : lut_s2;
      FINE_GAIN_O        <= oc_active ? rx_ctrl_pkg::FINE_MAX_DB : lut_fine;
      INPUT_SHORT_O      <= oc_active;
      CAL_DAC_O          <= cal_dac;
      OFFSET_CAL_BUSY_O  <= oc_active;
      FILTER_ENABLE_O    <= filter_power[rx_ctrl_pkg::FILTER_EN_BIT];
      CUTOFF_TARGET_O    <= cutoff_target;
      FILTER_CAL_START_O <= wr_target;
      FILTER_CAL_BUSY_O  <= fcal_busy;
      REG_RDATA_O        <= next_rdata;
    end
  end
endmodule // rx_gain_filter_calibration_control

// ---- rx_ctrl_pkg.sv ----
/*
  Shared constants for the receive gain, offset servo and filter calibration control.
  Assumes a single 40 MHz clock domain and the documented register port.
*/
package rx_ctrl_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_FILTER_POWER  = 8'h07;
  localparam logic [7:0] ADDR_CUTOFF_TARGET = 8'h08;
  localparam int         FILTER_EN_BIT      = 0;
  localparam logic [7:0] FILTER_POWER_RESET = 8'h01; // filter active after reset
  localparam logic [7:0] CUTOFF_RESET       = 8'h80;
  // ==========================================================
  // gain mapping
  localparam logic [5:0] GAIN_MAX_CODE   = 6'h3C;  // 60 steps: -12..+48 dB
  localparam logic [5:0] ALT_STEP_CODES  = 6'h08;  // 8 dB per short code step
  localparam logic [2:0] ALT_MAX_CODE    = 3'h6;   // -12..+36 dB
  localparam logic [3:0] COARSE_MAX_STEP = 4'h9;   // 0..9 steps of 6 dB
  localparam logic [5:0] COARSE_STEP_DB  = 6'h06;
  localparam logic [2:0] FINE_MAX_DB     = 3'h6;
  localparam logic [2:0] STAGE_HIGH_GAIN = 3'h7;   // forced during offset servo
  // ==========================================================
  // offset servo and timing
  localparam int         CAL_DAC_W       = 8;
  localparam logic [11:0] OFFSET_LIMIT   = 12'h020; // +/-32 LSB
  localparam real        CLK_MHZ         = 40.0;
  localparam real        FILTER_CAL_US   = 100.0;
  localparam int         FILTER_CAL_CYC  = int'(FILTER_CAL_US * CLK_MHZ) - 1; // busy ends by 100 us
  localparam int         SETTLE_CYC      = 16;
  typedef enum logic [1:0] {
    OC_IDLE   = 2'b00,
    OC_SETTLE = 2'b01,
    OC_MEAS   = 2'b10
  } oc_state_t;
endpackage

// ---- gain_lut.sv ----
/*
  Lookup from a 6-bit gain step to coarse and fine stage settings.
  Assumes the step input is already limited to the legal range.
*/
`timescale 1ns/1ps
module gain_lut (
  input  wire logic [5:0] step_i,
  output logic      [1:0] stage1_o,
  output logic      [2:0] stage2_o,
  output logic      [2:0] fine_o
);
  // ==========================================================
  // split: coarse part in 6 dB units, fine remainder 0..6 dB
  logic [3:0] coarse;
  logic [5:0] rem_db;
  assign coarse = (step_i / rx_ctrl_pkg::COARSE_STEP_DB > 6'(rx_ctrl_pkg::COARSE_MAX_STEP))
                  ? rx_ctrl_pkg::COARSE_MAX_STEP
                  : 4'(step_i / rx_ctrl_pkg::COARSE_STEP_DB);
  assign rem_db = step_i - 6'(coarse) * rx_ctrl_pkg::COARSE_STEP_DB;
  // first stage takes up to 3 steps, second the rest; keeps first stage low-noise
  assign stage1_o = (coarse > 4'h3) ? 2'h3 : coarse[1:0];
  assign stage2_o = (coarse > 4'h3) ? 3'(coarse - 4'h3) : 3'h0;
  assign fine_o   = (rem_db > 6'(rx_ctrl_pkg::FINE_MAX_DB))
                    ? rx_ctrl_pkg::FINE_MAX_DB : rem_db[2:0];
endmodule // gain_lut

// ---- rx_ctrl_chk.sv ----
/* port assertions for the receive gain, offset servo and filter calibration control
   assumes one 40 MHz clock and an active-low asynchronous reset */
`timescale 1ns/1ps
module rx_ctrl_chk #(
  parameter int CAL_DAC_W      = 8,
  parameter int FILTER_CAL_CYC = 50
) (
  input wire logic                 CLK_I,
  input wire logic                 RST_N_I,
  input wire logic [7:0]           REG_ADDR_I,
  input wire logic [7:0]           REG_WDATA_I,
  input wire logic                 REG_WR_I,
  input wire logic [1:0]           COARSE_STAGE1_O,
  input wire logic [2:0]           COARSE_STAGE2_O,
  input wire logic [2:0]           FINE_GAIN_O,
  input wire logic                 INPUT_SHORT_O,
  input wire logic [CAL_DAC_W-1:0] CAL_DAC_O,
  input wire logic                 OFFSET_CAL_BUSY_O,
  input wire logic                 FILTER_ENABLE_O,
  input wire logic [7:0]           CUTOFF_TARGET_O,
  input wire logic                 FILTER_CAL_START_O,
  input wire logic                 FILTER_CAL_BUSY_O
);
  // ========================================
  // helpers
  logic        en_bit;
  logic [15:0] busy_cnt;
  assign en_bit = REG_WDATA_I[0];
  // run length since the last start; a restart clears it, so one long run is a fault
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) busy_cnt <= 16'h0000;
    else busy_cnt <= (FILTER_CAL_BUSY_O && !FILTER_CAL_START_O) ? busy_cnt + 16'h0001 : 16'h0000;
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence tgt_wr;
    REG_WR_I && REG_ADDR_I == 8'h08;
  endsequence
  // ========================================
  // assertions
  a_short_busy: assert property (INPUT_SHORT_O == OFFSET_CAL_BUSY_O)
    else $error("input short differs from servo busy");
  a_forced_gain: assert property ($past(INPUT_SHORT_O) && INPUT_SHORT_O |->
    COARSE_STAGE1_O == 2'h3 && COARSE_STAGE2_O == 3'h7 && FINE_GAIN_O == 3'h6)
    else $error("stages not forced high during servo");
  a_fine_cap: assert property (FINE_GAIN_O <= 3'h6) else $error("fine gain above 6");
  a_coarse_order: assert property (COARSE_STAGE1_O != 2'h3 |-> COARSE_STAGE2_O == 3'h0)
    else $error("second stage used before first is full");
  a_write_start: assert property (tgt_wr |-> ##1 FILTER_CAL_START_O ##1 (FILTER_CAL_BUSY_O &&
    CUTOFF_TARGET_O == $past(REG_WDATA_I, 2))) else $error("target write did not start calibration");
  a_start_cause: assert property (FILTER_CAL_START_O |->
    $past(REG_WR_I) && $past(REG_ADDR_I) == 8'h08) else $error("start without target write");
  a_cal_bound: assert property (busy_cnt <= FILTER_CAL_CYC + 4)
    else $error("filter calibration ran too long");
  a_dac_still: assert property ($past(RST_N_I, 2) && !$stable(CAL_DAC_O) |->
    $past(OFFSET_CAL_BUSY_O)) else $error("dac code moved outside the servo");
  a_rst_servo: assert property ($rose(RST_N_I) |=> OFFSET_CAL_BUSY_O && INPUT_SHORT_O)
    else $error("servo did not start after reset");
  a_filter_bit: assert property (REG_WR_I && REG_ADDR_I == 8'h07 |->
    ##2 FILTER_ENABLE_O == $past(en_bit, 2)) else $error("filter enable not updated");
endmodule // rx_ctrl_chk
bind rx_gain_filter_calibration_control rx_ctrl_chk #(.CAL_DAC_W(CAL_DAC_W),
  .FILTER_CAL_CYC(FILTER_CAL_CYC)) rx_ctrl_chk_i (.*);

// ---- rx_analog_model.sv ----
/* analog receive side: offset readings while shorted, filter calibration done
   assumes the control block's registered outputs and the same clock */
`timescale 1ns/1ps
module rx_analog_model (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         short_i,
  input  wire logic [7:0]   dac_i,
  input  wire logic         start_i,
  input  wire logic         slow_i,
  output logic              valid_o,
  output logic signed [11:0] meas_o,
  output logic              done_o
);
  logic [3:0] wait_cnt;
  // offset is 100 LSB at midscale, 8 LSB less per code below; released line toggles
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      valid_o <= 1'b0;
      meas_o <= 12'h5A5;
      done_o <= 1'b0;
      wait_cnt <= 4'h0;
    end else begin
      valid_o <= short_i;
      meas_o <= short_i ? ((({4'h0, dac_i} - 12'h080) << 3) + 12'h064) : ~meas_o;
      done_o <= (wait_cnt == 4'h1);
      if (start_i) wait_cnt <= slow_i ? 4'h0 : 4'h6; // slow never answers
      else if (wait_cnt != 4'h0) wait_cnt <= wait_cnt - 4'h1;
    end
  end
endmodule // rx_analog_model

// ---- rx_gain_filter_calibration_control_tb_top.sv ----
/* self-checking bench for the receive control block
   assumes the analog model and the bound checker; short calibration count */
`timescale 1ns/1ps
module rx_gain_filter_calibration_control_tb_top;
  logic        CLK_I, RST_N_I, REG_WR_I, ALT_GAIN_SEL_I, OFFSET_CAL_REQ_I, OFFSET_VALID_I;
  logic        FILTER_CAL_DONE_I, INPUT_SHORT_O, OFFSET_CAL_BUSY_O, FILTER_ENABLE_O;
  logic        FILTER_CAL_START_O, FILTER_CAL_BUSY_O, slow;
  logic [7:0]  REG_ADDR_I, REG_WDATA_I, REG_RDATA_O, CAL_DAC_O, CUTOFF_TARGET_O, d;
  logic [5:0]  GAIN_WORD_I;
  logic [2:0]  ALT_GAIN_I, COARSE_STAGE2_O, FINE_GAIN_O;
  logic [1:0]  COARSE_STAGE1_O;
  logic [31:0] r;
  logic signed [11:0] OFFSET_MEAS_I;
  int          seed, i, cycles, num_errors, check_count;
  rx_gain_filter_calibration_control #(.FILTER_CAL_CYC(50)) rx_gain_filter_calibration_control_i (.*);
  rx_analog_model rx_analog_model_i (.clk_i(CLK_I), .rst_n_i(RST_N_I), .short_i(INPUT_SHORT_O),
    .dac_i(CAL_DAC_O), .start_i(FILTER_CAL_START_O), .slow_i(slow), .valid_o(OFFSET_VALID_I),
    .meas_o(OFFSET_MEAS_I), .done_o(FILTER_CAL_DONE_I));
  // ========================================
  // helpers
  function automatic logic [7:0] exp_gain(input logic [5:0] g, input logic [2:0] a, input logic s);
    int v, c;
    v = s ? ((a > 6) ? 6 : a) * 8 : ((g > 60) ? 60 : g);
    c = (v / 6 > 9) ? 9 : v / 6;
    return {(c > 3) ? 2'h3 : 2'(c), (c > 3) ? 3'(c - 3) : 3'h0, (v - 6 * c > 6) ? 3'h6 : 3'(v - 6 * c)};
  endfunction
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n); repeat (n) @(posedge CLK_I); #1; endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    REG_ADDR_I = a; REG_WDATA_I = v; REG_WR_I = 1'b1; step(1); REG_WR_I = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] v);
    REG_ADDR_I = a; step(1); chk(REG_RDATA_O, v);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin CLK_I = 1'b0; forever #12.5 CLK_I = ~CLK_I; end
  // a hang is cut short well above the expected run of under a thousand cycles
  always @(posedge CLK_I) begin
    cycles++;
    if (cycles == 5000) begin num_errors++; summarize(); end
  end
  // ========================================
  // scenarios
  initial begin
    seed = 32'h8E40; RST_N_I = 1'b0; REG_ADDR_I = 8'h00; REG_WDATA_I = 8'h00; REG_WR_I = 1'b0;
    GAIN_WORD_I = 6'h00; ALT_GAIN_I = 3'h0; ALT_GAIN_SEL_I = 1'b0; OFFSET_CAL_REQ_I = 1'b0; slow = 1'b0;
    step(2); RST_N_I = 1'b1; step(1);
    chk(OFFSET_CAL_BUSY_O, 1'b1); chk(INPUT_SHORT_O, 1'b1);
    rd(8'h07, 8'h01); rd(8'h08, 8'h80); chk(FILTER_ENABLE_O, 1'b1);
    chk({COARSE_STAGE1_O, COARSE_STAGE2_O, FINE_GAIN_O}, 8'hFE);
    while (OFFSET_CAL_BUSY_O !== 1'b0) step(1);
    chk(CAL_DAC_O, 8'h77); chk(INPUT_SHORT_O, 1'b0);
    OFFSET_CAL_REQ_I = 1'b1; step(1); OFFSET_CAL_REQ_I = 1'b0; step(1);
    chk(OFFSET_CAL_BUSY_O, 1'b1);
    while (OFFSET_CAL_BUSY_O !== 1'b0) step(1);
    chk(CAL_DAC_O, 8'h77);
    $display("offset servo test done");
    // every gain code, every short code, then random mixes
    for (i = 0; i < 88; i++) begin
      r = $random(seed);
      GAIN_WORD_I = (i < 64) ? 6'(i) : r[5:0];
      ALT_GAIN_I = (i < 64) ? r[8:6] : 3'(i);
      ALT_GAIN_SEL_I = (i < 64) ? 1'b0 : ((i < 72) | r[9]);
      step(3);
      chk({COARSE_STAGE1_O, COARSE_STAGE2_O, FINE_GAIN_O}, exp_gain(GAIN_WORD_I, ALT_GAIN_I, ALT_GAIN_SEL_I));
    end
    $display("gain mapping test done");
    d = 8'($random(seed));
    wr(8'h08, d); chk(FILTER_CAL_START_O, 1'b1);
    step(1); chk(FILTER_CAL_START_O, 1'b0); chk(FILTER_CAL_BUSY_O, 1'b1);
    chk(CUTOFF_TARGET_O, d);
    step(4); wr(8'h08, d); chk(FILTER_CAL_START_O, 1'b1);
    step(16); chk(FILTER_CAL_BUSY_O, 1'b0);
    slow = 1'b1; wr(8'h08, ~d); step(20); wr(8'h08, d);
    step(44); chk(FILTER_CAL_BUSY_O, 1'b1);
    step(12); chk(FILTER_CAL_BUSY_O, 1'b0); rd(8'h08, d);
    slow = 1'b0;
    $display("filter calibration test done");
    wr(8'h07, 8'h00); step(1); chk(FILTER_ENABLE_O, 1'b0); rd(8'h07, 8'h00);
    wr(8'h07, 8'h01); step(1); chk(FILTER_ENABLE_O, 1'b1);
    wr(8'h3C, 8'h5A); rd(8'h3C, 8'h00); rd(8'h08, d);
    RST_N_I = 1'b0; step(2); RST_N_I = 1'b1; step(1);
    chk(OFFSET_CAL_BUSY_O, 1'b1); rd(8'h08, 8'h80);
    $display("register and reset test done");
    summarize();
  end
endmodule // rx_gain_filter_calibration_control_tb_top
